// ---- hw/dac_ctrl_pkg.sv ----
// constants shared by the quad converter control core and its serial receiver
// assumes: 250 MHz core clock, 24-bit serial frames, four 16-bit channels
package dac_ctrl_pkg;

  // channel count and widths
  localparam int NUM_CH     = 4;
  localparam int CODE_W     = 16;
  localparam int FRAME_BITS = 24;

  // frame field positions, msb first on the wire
  localparam int RW_POS  = 23;   // 1 = readback request
  localparam int REG_HI  = 21;   // register select
  localparam int REG_LO  = 19;
  localparam int CH_HI   = 18;   // channel address
  localparam int CH_LO   = 16;
  localparam int DATA_HI = 15;   // data occupies DATA_HI..0

  // falling-edge count that makes a frame valid, and the saturation point
  localparam logic [4:0] FRAME_LEN = 5'h18;
  localparam logic [4:0] CNT_SAT   = 5'h19;

  // register select codes
  localparam logic [2:0] REG_DAC   = 3'h0;
  localparam logic [2:0] REG_RANGE = 3'h1;
  localparam logic [2:0] REG_POWER = 3'h2;
  localparam logic [2:0] REG_CTRL  = 3'h3;

  // channel address meaning every channel, and control functions
  localparam logic [2:0] CH_ALL      = 3'h4;
  localparam logic [2:0] CTRL_CONFIG = 3'h1;
  localparam logic [2:0] CTRL_CLEAR  = 3'h4;
  localparam int         CLEAR_SEL_POS = 2;

  // output range codes: 0..2 unipolar, 3..5 bipolar
  localparam logic [2:0] RANGE_UNI5   = 3'h0;
  localparam logic [2:0] RANGE_BIP5   = 3'h3;
  localparam logic [2:0] RANGE_BIP10  = 3'h4;
  localparam logic [2:0] RANGE_BIP108 = 3'h5;

  // code values
  localparam logic [15:0] ZERO_SCALE = 16'h0000;
  localparam logic [15:0] MID_SCALE  = 16'h8000;
  localparam logic [15:0] SIGN_FLIP  = 16'h8000;

  // reset values
  localparam logic [15:0] RESET_CODE      = 16'h0000;
  localparam logic [2:0]  RESET_RANGE     = 3'h0;
  localparam logic [3:0]  RESET_POWER     = 4'h0;
  localparam logic        RESET_CLEAR_SEL = 1'b0;

  // avalon byte offsets
  localparam logic [7:0] A_CODE   = 8'h00;
  localparam logic [7:0] A_RANGE  = 8'h10;
  localparam logic [7:0] A_POWER  = 8'h20;
  localparam logic [7:0] A_CFG    = 8'h24;
  localparam logic [7:0] A_CLEAR  = 8'h28;
  localparam logic [7:0] A_STATUS = 8'h2C;
  localparam int STAT_CLEAR_POS  = 0;
  localparam int STAT_CODING_POS = 1;

  // receiver states
  typedef enum logic {
    RX_IDLE  = 1'b0,
    RX_FRAME = 1'b1
  } rx_state_e;

endpackage : dac_ctrl_pkg

// ---- hw/link_frame_if.sv ----
// carrier between the serial receiver and the control core
// assumes: both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface link_frame_if;
  logic        frame_valid;  // one-cycle pulse, a complete frame arrived
  logic [23:0] frame_word;   // the frame, msb first as received
  logic [15:0] read_word;    // value to shift out during the next frame

  modport rx   (output frame_valid, output frame_word, input read_word);
  modport core (input frame_valid, input frame_word, output read_word);
endinterface : link_frame_if
`default_nettype wire

// ---- hw/quad_dac_clear_config_coding.sv ----
// control core of a quad serially programmed voltage-output converter
// assumes: pins asynchronous to clk; avalon master on clk; ce gates everything
`timescale 1ns/1ps
`default_nettype none
module quad_dac_clear_config_coding
  import dac_ctrl_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // serial link pins
  input  wire logic        serial_clk,
  input  wire logic        frame_sync_n,
  input  wire logic        serial_in,
  output logic             serial_out,
  // control pins
  input  wire logic        async_clear_n,
  input  wire logic        bipolar_coding_select,  // 1 = twos complement
  // avalon-mm slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // converter side
  output logic [63:0]      dac_drive,    // straight codes for the four strings
  output logic [3:0]       ch_bipolar,
  output logic [3:0]       ch_powered,
  output logic             clear_active
);

  link_frame_if lf ();

  logic [1:0]  clr_q;          // clear pin synchroniser
  logic [1:0]  coding_q;       // coding pin synchroniser
  logic [15:0] code [4];       // stored channel codes
  logic [2:0]  range_sel [4];  // per-channel range
  logic [3:0]  power;          // 1 = channel powered up
  logic        clear_sel;      // 1 = midscale
  logic        pin_clear;
  logic        clear_cmd;
  logic        clearing;
  logic [3:0]  bip;
  logic [3:0]  tc;
  logic [15:0] clear_raw [4];
  // two write sources: 0 = serial frame, 1 = avalon (wins on same target)
  logic        s_en [2];
  logic [2:0]  s_reg [2];
  logic [2:0]  s_ch [2];
  logic [15:0] s_data [2];
  logic [3:0]  code_we;
  logic [15:0] code_wd [4];
  logic [3:0]  range_we;
  logic [2:0]  range_wd [4];
  logic        power_we;
  logic [3:0]  power_wd;
  logic        cfg_we;
  logic        cfg_wd;
  logic        a_hit;          // avalon address maps to a writable register
  logic        a_stat;         // avalon address is the status word
  logic [2:0]  a_reg;
  logic [2:0]  a_ch;
  logic        av_take;

  serial_frame_rx u_rx (
    .clk          (clk),
    .rstn         (rstn),
    .ce           (ce),
    .serial_clk   (serial_clk),
    .frame_sync_n (frame_sync_n),
    .serial_in    (serial_in),
    .serial_out   (serial_out),
    .lf           (lf.rx)
  );

  // bipolar when range code is one of the three bipolar settings
  function automatic logic is_bipolar(input logic [2:0] r);
    is_bipolar = (r == RANGE_BIP5) || (r == RANGE_BIP10) || (r == RANGE_BIP108);
  endfunction : is_bipolar

  // register view shared by serial readback and avalon reads
  function automatic logic [15:0] reg_view(input logic [2:0] rs, input logic [2:0] ch);
    reg_view = 16'h0000;
    if (ch[2] == 1'b0 || rs == REG_POWER || rs == REG_CTRL) begin
      case (rs)
        REG_DAC:   reg_view = code[ch[1:0]];
        REG_RANGE: reg_view = {13'h0000, range_sel[ch[1:0]]};
        REG_POWER: reg_view = {12'h000, power};
        REG_CTRL:  reg_view = {13'h0000, clear_sel, 2'h0};
        default:   reg_view = 16'h0000;
      endcase
    end
  endfunction : reg_view

  // pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clr_q    <= 2'h3;
      coding_q <= 2'h0;
    end else if (ce) begin
      clr_q    <= {clr_q[0], async_clear_n};
      coding_q <= {coding_q[0], bipolar_coding_select};
    end
  end

  assign pin_clear = ~clr_q[1];
  assign clearing  = pin_clear | clear_cmd;
  assign av_take   = (read | write) & ~waitrequest;

  // per-channel coding and the raw code that yields the selected clear level
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      bip[c] = is_bipolar(range_sel[c]);
      tc[c]  = bip[c] & coding_q[1];
      // a raw code that drives zero-scale or midscale under the channel's coding
      clear_raw[c] = (clear_sel ? MID_SCALE : ZERO_SCALE)
                     ^ (tc[c] ? SIGN_FLIP : 16'h0000);
    end
  end

  // avalon address decode; misaligned or unknown offsets map to nothing
  always_comb begin
    a_hit  = 1'b0;
    a_stat = 1'b0;
    a_reg  = REG_DAC;
    a_ch   = 3'h0;
    if (address[1:0] == 2'h0) begin
      if (address[7:4] == A_CODE[7:4]) begin
        a_hit = 1'b1;
        a_ch  = {1'b0, address[3:2]};
      end else if (address[7:4] == A_RANGE[7:4]) begin
        a_hit = 1'b1;
        a_reg = REG_RANGE;
        a_ch  = {1'b0, address[3:2]};
      end else if (address == A_POWER) begin
        a_hit = 1'b1;
        a_reg = REG_POWER;
      end else if (address == A_CFG) begin
        a_hit = 1'b1;
        a_reg = REG_CTRL;
        a_ch  = CTRL_CONFIG;
      end else if (address == A_CLEAR) begin
        a_hit = 1'b1;
        a_reg = REG_CTRL;
        a_ch  = CTRL_CLEAR;
      end else if (address == A_STATUS) begin
        a_stat = 1'b1;
      end
    end
  end

  // the two write sources in one form
  always_comb begin
    s_en[0]   = lf.frame_valid & ~lf.frame_word[RW_POS];
    s_reg[0]  = lf.frame_word[REG_HI:REG_LO];
    s_ch[0]   = lf.frame_word[CH_HI:CH_LO];
    s_data[0] = lf.frame_word[DATA_HI:0];
    s_en[1]   = av_take & write & a_hit & byteenable[0];
    s_reg[1]  = a_reg;
    s_ch[1]   = a_ch;
    s_data[1] = writedata[15:0];
  end

  // write strobes; a later source overrides an earlier one
  always_comb begin
    code_we   = 4'h0;
    range_we  = 4'h0;
    power_we  = 1'b0;
    power_wd  = power;
    cfg_we    = 1'b0;
    cfg_wd    = clear_sel;
    clear_cmd = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      code_wd[c]  = code[c];
      range_wd[c] = range_sel[c];
    end
    for (int s = 0; s < 2; s++) begin
      if (s_en[s]) begin
        case (s_reg[s])
          REG_DAC, REG_RANGE: begin
            for (int c = 0; c < NUM_CH; c++) begin
              if (s_ch[s] == 3'(c) || s_ch[s] == CH_ALL) begin
                if (s_reg[s] == REG_DAC) begin
                  code_we[c] = 1'b1;
                  code_wd[c] = s_data[s];
                end else begin
                  range_we[c] = 1'b1;
                  range_wd[c] = s_data[s][2:0];
                end
              end
            end
          end
          REG_POWER: begin
            power_we = 1'b1;
            power_wd = s_data[s][3:0];
          end
          REG_CTRL: begin
            if (s_ch[s] == CTRL_CONFIG) begin
              cfg_we = 1'b1;
              cfg_wd = s_data[s][CLEAR_SEL_POS];
            end else if (s_ch[s] == CTRL_CLEAR) begin
              clear_cmd = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // stored codes: clear wins over any write, powered-down writes dropped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < NUM_CH; c++) begin
        code[c] <= RESET_CODE;
      end
    end else if (ce) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (clearing) begin
          code[c] <= clear_raw[c];
        end else if (code_we[c] && power[c]) begin
          code[c] <= code_wd[c];
        end
      end
    end
  end

  // configuration registers; reset leaves every channel powered down
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      power     <= RESET_POWER;
      clear_sel <= RESET_CLEAR_SEL;
      for (int c = 0; c < NUM_CH; c++) begin
        range_sel[c] <= RESET_RANGE;
      end
    end else if (ce) begin
      if (power_we) begin
        power <= power_wd;
      end
      if (cfg_we) begin
        clear_sel <= cfg_wd;
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (range_we[c]) begin
          range_sel[c] <= range_wd[c];
        end
      end
    end
  end

  // drive codes: straight and offset binary pass, twos complement flips the sign
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dac_drive    <= 64'h0000_0000_0000_0000;
      ch_bipolar   <= 4'h0;
      ch_powered   <= 4'h0;
      clear_active <= 1'b0;
    end else if (ce) begin
      for (int c = 0; c < NUM_CH; c++) begin
        dac_drive[c*16 +: 16] <= code[c] ^ (tc[c] ? SIGN_FLIP : 16'h0000);
      end
      ch_bipolar   <= bip;
      ch_powered   <= power;
      clear_active <= clearing;
    end
  end

  // serial readback: the addressed register is latched for the next frame
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lf.read_word <= 16'h0000;
    end else if (ce) begin
      if (lf.frame_valid && lf.frame_word[RW_POS]) begin
        lf.read_word <= reg_view(lf.frame_word[REG_HI:REG_LO], lf.frame_word[CH_HI:CH_LO]);
      end
    end
  end

  // avalon slave: waitrequest drops one cycle after a request, for one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if (ce) begin
      if (waitrequest && (read || write)) begin
        waitrequest <= 1'b0;
        if (a_stat) begin
          readdata <= {30'h0000_0000, coding_q[1], pin_clear};
        end else if (a_hit && a_ch != CTRL_CLEAR) begin
          readdata <= {16'h0000, reg_view(a_reg, a_ch)};
        end else begin
          readdata <= 32'h0000_0000;  // unmapped and clear command read zero
        end
      end else begin
        waitrequest <= 1'b1;
      end
    end
  end

  // checks on the core clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_clear_all;
    ce && clearing |=> code[0] == $past(clear_raw[0]) && code[3] == $past(clear_raw[3]);
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear did not load channels");

  property p_mid_select;
    ce && clearing && clear_sel ##1 ce && $stable(tc) |=> dac_drive[31:16] == MID_SCALE;
  endproperty
  a_mid_select: assert property (p_mid_select) else $error("midscale clear not driven");

  property p_hold_code;
    ce && !clearing && !(code_we[2] && power[2]) |=> code[2] == $past(code[2]);
  endproperty
  a_hold_code: assert property (p_hold_code) else $error("code changed without write");

  property p_block_write;
    ce && pin_clear && code_we[1] && power[1] |=> code[1] != $past(code_wd[1])
      || $past(code_wd[1]) == $past(clear_raw[1]);
  endproperty
  a_block_write: assert property (p_block_write) else $error("write passed during clear");

  property p_cmd_clear;
    ce && clear_cmd && !pin_clear |=> code[1] == $past(clear_raw[1]) && clear_active;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("clear command ignored");

  property p_reset_state;
    !$past(rstn) |-> power == 4'h0 && range_sel[0] == RANGE_UNI5 && !ch_bipolar[0];
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

  property p_drop_powered_down;
    ce && !clearing && code_we[2] && !power[2] |=> $stable(code[2]);
  endproperty
  a_drop_powered_down: assert property (p_drop_powered_down) else $error("write hit down channel");

  property p_unipolar_straight;
    ce && !bip[0] |=> dac_drive[15:0] == $past(code[0]);
  endproperty
  a_unipolar_straight: assert property (p_unipolar_straight) else $error("unipolar code altered");

  property p_offset_mid;
    ce && bip[1] && !coding_q[1] && code[1] == MID_SCALE |=> dac_drive[31:16] == MID_SCALE;
  endproperty
  a_offset_mid: assert property (p_offset_mid) else $error("offset binary zero wrong");

  property p_twos_zero;
    ce && tc[1] && code[1] == 16'h0000 |=> dac_drive[31:16] == MID_SCALE;
  endproperty
  a_twos_zero: assert property (p_twos_zero) else $error("twos complement zero wrong");

  property p_frame_power;
    ce && s_en[0] && s_reg[0] == REG_POWER && !s_en[1] |=> power == $past(s_data[0][3:0]);
  endproperty
  a_frame_power: assert property (p_frame_power) else $error("frame write not applied");

  c_pin_clear: cover property (ce && pin_clear ##1 ce && !pin_clear);
  c_frame_write: cover property (s_en[0] && s_reg[0] == REG_DAC && power[0]);
  c_avalon_read: cover property (av_take && read);
  c_cmd_clear: cover property (clear_cmd);

endmodule : quad_dac_clear_config_coding
`default_nettype wire

// ---- hw/serial_frame_rx.sv ----
// three-wire serial receiver with readback shift-out
// assumes: pins are asynchronous to clk and slower than a quarter of it
`timescale 1ns/1ps
`default_nettype none
module serial_frame_rx
  import dac_ctrl_pkg::*;
(
  // clock, reset and enable
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  // serial pins
  input  wire logic serial_clk,
  input  wire logic frame_sync_n,
  input  wire logic serial_in,
  output logic      serial_out,
  // frame carrier
  link_frame_if.rx  lf
);

  logic [2:0]  clk_q;      // synchroniser plus one history stage
  logic [2:0]  sync_q;
  logic [1:0]  din_q;
  rx_state_e   state;
  logic [4:0]  fall_cnt;   // saturates so overlong frames stay invalid
  logic [23:0] in_sr;
  logic [23:0] out_sr;
  logic        clk_fall;
  logic        clk_rise;
  logic        sync_fall;
  logic        sync_rise;

  // edges are taken from stages 1 and 2 only, never from stage 0
  assign clk_fall  = ~clk_q[1] & clk_q[2];
  assign clk_rise  = clk_q[1] & ~clk_q[2];
  assign sync_fall = ~sync_q[1] & sync_q[2];
  assign sync_rise = sync_q[1] & ~sync_q[2];

  // pin synchronisers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_q  <= 3'h7;  // matches the idle-high link clock, so no false edge after reset
      sync_q <= 3'h7;
      din_q  <= 2'h0;
    end else if (ce) begin
      clk_q  <= {clk_q[1:0], serial_clk};
      sync_q <= {sync_q[1:0], frame_sync_n};
      din_q  <= {din_q[0], serial_in};
    end
  end

  // framing: data sampled on falling clock, frame closes on sync rise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state          <= RX_IDLE;
      fall_cnt       <= 5'h00;
      in_sr          <= 24'h00_0000;
      lf.frame_valid <= 1'b0;
      lf.frame_word  <= 24'h00_0000;
    end else if (ce) begin
      lf.frame_valid <= 1'b0;
      if (sync_fall) begin
        state    <= RX_FRAME;
        fall_cnt <= 5'h00;
      end else if (state == RX_FRAME) begin
        if (sync_rise) begin
          // short or long frames are dropped silently
          state          <= RX_IDLE;
          lf.frame_valid <= (fall_cnt == FRAME_LEN);
          lf.frame_word  <= in_sr;
        end else if (clk_fall) begin
          in_sr <= {in_sr[22:0], din_q[1]};
          if (fall_cnt != CNT_SAT) begin
            fall_cnt <= fall_cnt + 5'h01;
          end
        end
      end
    end
  end

  // readback: loaded at frame start, shifted on rising clock after the first fall
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_sr     <= 24'h00_0000;
      serial_out <= 1'b0;
    end else if (ce) begin
      if (sync_fall) begin
        out_sr     <= {8'h00, lf.read_word};
        serial_out <= 1'b0;
      end else if (state == RX_FRAME && clk_rise && fall_cnt != 5'h00) begin
        out_sr     <= {out_sr[22:0], 1'b0};
        serial_out <= out_sr[22];
      end
    end
  end

endmodule : serial_frame_rx
`default_nettype wire

// ---- testbench/serial_host_model.sv ----
// host serial master model that drives the converter's three-wire link
// assumes: tb_top calls send(); clk is the 250 MHz core clock
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  // core clock
  input  wire logic clk,
  // serial pins
  output logic      serial_clk,
  output logic      frame_sync_n,
  output logic      serial_in,
  input  wire logic serial_out
);
  localparam int HALF = 10;  // 40 ns half period, 80 ns link clock

  // link clock stands still high between frames
  initial begin
    serial_clk   = 1'b1;
    frame_sync_n = 1'b1;
    serial_in    = 1'b0;
  end

  // one frame of exactly 24 falls, msb first; returns readback bits
  task automatic send(input logic [23:0] w, output logic [23:0] back);
    @(posedge clk);
    frame_sync_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      serial_in  <= w[i];
      serial_clk <= 1'b1;
      repeat (HALF) @(posedge clk);
      back[i] = serial_out;  // settled well before the fall
      serial_clk <= 1'b0;
      repeat (HALF) @(posedge clk);
    end
    serial_clk <= 1'b1;
    repeat (HALF) @(posedge clk);
    frame_sync_n <= 1'b1;
    serial_in    <= ~w[0];  // released data line must not look held
    repeat (2 * HALF) @(posedge clk);
  endtask : send
endmodule : serial_host_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the quad converter control core
// assumes: design package compiled first; avalon master and link host here
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dac_ctrl_pkg::*;
  // clock, reset and pins
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        serial_clk, frame_sync_n, serial_in, serial_out;
  logic        async_clear_n = 1'b1;
  logic        bipolar_coding_select = 1'b0;
  // avalon master side
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic        waitrequest;
  // converter side
  logic [63:0] dac_drive;
  logic [3:0]  ch_bipolar, ch_powered;
  logic        clear_active;
  int          fails = 0;
  int          samples_checked = 0;
  logic [31:0] q;
  logic [23:0] back;

  always #2 clk = ~clk;

  quad_dac_clear_config_coding quad_dac_clear_config_coding_i (
    .clk(clk), .rstn(rstn), .ce(1'b1), .serial_clk(serial_clk),
    .frame_sync_n(frame_sync_n), .serial_in(serial_in), .serial_out(serial_out),
    .async_clear_n(async_clear_n), .bipolar_coding_select(bipolar_coding_select),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .dac_drive(dac_drive), .ch_bipolar(ch_bipolar), .ch_powered(ch_powered),
    .clear_active(clear_active));

  serial_host_model serial_host_model_i (
    .clk(clk), .serial_clk(serial_clk), .frame_sync_n(frame_sync_n),
    .serial_in(serial_in), .serial_out(serial_out));

  // one comparison, unknowns never match
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one avalon access; request held until waitrequest sampled low
  // a slave that never answers is caught by the watchdog
  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : av

  // serial write frame: rw 0, spare bit, register, channel, data
  task automatic fr(input logic [2:0] r, input logic [2:0] c, input logic [15:0] d);
    serial_host_model_i.send({2'b00, r, c, d}, back);
  endtask : fr

  // reset leaves everything zero, ranges unipolar, channels down
  task automatic t_reset;
    chk("drive", 64'h0, dac_drive);
    chk("powered", 64'h0, ch_powered);
    chk("bipolar", 64'h0, ch_bipolar);
    av(1'b0, A_RANGE, 32'h0);
    chk("range0", 64'h0, q);
    av(1'b0, A_CFG, 32'h0);
    chk("cfg", 64'h0, q);
    $display("test reset done");
  endtask : t_reset

  // recommended bring-up; writes to channels still down are dropped
  task automatic t_config;
    fr(REG_DAC, 3'h0, 16'h1234);
    av(1'b1, A_CODE + 8'h08, 32'h5555);
    repeat (3) @(posedge clk);
    chk("down drive", 64'h0, dac_drive);
    fr(REG_RANGE, CH_ALL, {13'h0, RANGE_UNI5});
    fr(REG_POWER, 3'h0, 16'h000F);
    chk("powered", 64'hF, ch_powered);
    fr(REG_DAC, 3'h0, 16'hFFFF);
    chk("uni full", 64'hFFFF, dac_drive[15:0]);
    serial_host_model_i.send({1'b1, 1'b0, REG_DAC, 3'h0, 16'h0}, back);
    // control register, channel 0: a frame that changes nothing
    serial_host_model_i.send({2'b00, REG_CTRL, 3'h0, 16'h0}, back);
    chk("readback", 64'h00FFFF, back);
    $display("test config done");
  endtask : t_config

  // bipolar coding under both levels of the coding pin
  task automatic t_coding;
    logic [15:0] c;
    av(1'b1, A_RANGE + 8'h04, {29'h0, RANGE_BIP5});
    repeat (2) @(posedge clk);
    chk("bip1", 64'h2, ch_bipolar);
    for (int p = 0; p < 2; p++) begin
      bipolar_coding_select <= p[0];
      repeat (8) @(posedge clk);
      for (int k = 0; k < 4; k++) begin
        c = (k == 0) ? 16'h0000 : (k == 1) ? 16'h8000 : (k == 2) ? 16'h7FFF : 16'hFFFF;
        av(1'b1, A_CODE + 8'h04, {16'h0, c});
        repeat (3) @(posedge clk);
        chk("coded", p ? c ^ SIGN_FLIP : c, dac_drive[31:16]);
      end
    end
    $display("test coding done");
  endtask : t_coding

  // clear pin, held code, blocked writes, command clear to midscale
  task automatic t_clear;
    async_clear_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("clear flag", 64'h1, clear_active);
    chk("cleared", {4{ZERO_SCALE}}, dac_drive);
    av(1'b1, A_CODE + 8'h04, 32'h1111);
    repeat (3) @(posedge clk);
    chk("blocked", {4{ZERO_SCALE}}, dac_drive);
    async_clear_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk("held", {4{ZERO_SCALE}}, dac_drive);
    av(1'b1, A_CFG, 32'h1 << CLEAR_SEL_POS);
    av(1'b1, A_CLEAR, 32'h0);
    repeat (4) @(posedge clk);
    chk("mid", {4{MID_SCALE}}, dac_drive);
    av(1'b1, A_CODE + 8'h0C, 32'h0042);
    repeat (3) @(posedge clk);
    chk("new ch3", 64'h0042, dac_drive[63:48]);
    // pin clear with midscale selected
    async_clear_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("pin mid", {4{MID_SCALE}}, dac_drive);
    async_clear_n <= 1'b1;
    repeat (4) @(posedge clk);
    av(1'b0, 8'hF0, 32'h0);
    chk("unmapped", 64'h0, q);
    $display("test clear done");
  endtask : t_clear

  // verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_config();
    t_coding();
    t_clear();
    wrap_up();
  end

  // watchdog well beyond about 3200 expected cycles
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
